// ===== include/desc_byte_if.sv
`timescale 1ns/1ns
`default_nettype none
interface desc_byte_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  logic last;
  modport src (output valid, output data, output last, input ready);
  modport sink (input valid, input data, input last, output ready);
endinterface
`default_nettype wire

// ===== include/hub_desc_pkg.sv
package hub_desc_pkg;

  // ---------------------------------------------------------------
  // Descriptor lengths and types
  // ---------------------------------------------------------------
  localparam logic [7:0] LEN_DEVICE = 8'h12;
  localparam logic [7:0] LEN_QUALIFIER = 8'h0a;
  localparam logic [7:0] LEN_CONFIG = 8'h09;
  localparam logic [7:0] LEN_INTERFACE = 8'h09;
  localparam logic [7:0] LEN_ENDPOINT = 8'h07;
  localparam logic [7:0] TYPE_DEVICE = 8'h01;
  localparam logic [7:0] TYPE_CONFIG = 8'h02;
  localparam logic [7:0] TYPE_INTERFACE = 8'h04;
  localparam logic [7:0] TYPE_ENDPOINT = 8'h05;
  localparam logic [7:0] TYPE_QUALIFIER = 8'h06;
  localparam logic [7:0] TYPE_OTHER_SPEED = 8'h07;

  // ---------------------------------------------------------------
  // Device and qualifier fields
  // ---------------------------------------------------------------
  localparam logic [15:0] USB_RELEASE = 16'h0200;
  localparam logic [7:0] HUB_CLASS = 8'h09;
  localparam logic [7:0] HUB_SUBCLASS = 8'h00;
  localparam logic [7:0] DEV_PROTOCOL = 8'h01;
  localparam logic [7:0] QUAL_PROTOCOL = 8'h00;
  localparam logic [7:0] EP0_MAX_PACKET = 8'h40;
  localparam logic [7:0] NUM_CONFIGS = 8'h01;
  localparam logic [7:0] STRING_NONE = 8'h00;
  localparam logic [7:0] RESERVED_ZERO = 8'h00;
  localparam logic [7:0] RELEASE_LOW = 8'h00;
  localparam logic [6:0] OFS_VENDOR = 7'h08;
  localparam logic [6:0] OFS_PRODUCT = 7'h0a;
  localparam logic [6:0] OFS_RELEASE = 7'h0c;

  // ---------------------------------------------------------------
  // Configuration, interface and endpoint fields
  // ---------------------------------------------------------------
  localparam logic [15:0] TOTAL_SINGLE = 16'h0019;
  localparam logic [15:0] TOTAL_MULTI = 16'h0029;
  localparam logic [7:0] NUM_INTERFACES = 8'h01;
  localparam logic [7:0] CONFIG_VALUE = 8'h01;
  localparam logic [7:0] ATTR_BUS = 8'ha0;
  localparam logic [7:0] ATTR_SELF = 8'he0;
  localparam logic [7:0] IF_NUMBER = 8'h00;
  localparam logic [7:0] ALT_SINGLE = 8'h00;
  localparam logic [7:0] ALT_MULTI = 8'h01;
  localparam logic [7:0] IF_ENDPOINTS = 8'h01;
  localparam logic [7:0] PROTO_SINGLE = 8'h00;
  localparam logic [7:0] PROTO_MULTI = 8'h02;
  localparam logic [7:0] EP_ADDRESS = 8'h81;
  localparam logic [7:0] EP_XFER_INTERRUPT = 8'h03;
  localparam logic [15:0] EP_MAX_PACKET = 16'h0001;
  localparam logic [7:0] EP_INTERVAL = 8'h0c;

  // ---------------------------------------------------------------
  // Segment starts inside a configuration set
  // ---------------------------------------------------------------
  localparam logic [6:0] SEG_IF0 = 7'h09;
  localparam logic [6:0] SEG_EP0 = 7'h12;
  localparam logic [6:0] SEG_IF1 = 7'h19;
  localparam logic [6:0] SEG_EP1 = 7'h22;

  // ---------------------------------------------------------------
  // Reset values and types
  // ---------------------------------------------------------------
  localparam logic [6:0] RESET_COUNT = 7'h00;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [1:0] {
    KIND_DEVICE = 2'b00,
    KIND_QUALIFIER = 2'b01,
    KIND_CONFIG = 2'b10,
    KIND_OTHER_SPEED = 2'b11
  } desc_kind_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } fsm_t;

endpackage

// ===== logic/byte_stage.sv
`timescale 1ns/1ns
`default_nettype none
module byte_stage (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Byte offer from the sequencer
  desc_byte_if.sink in,
  // Byte stream to the host side
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  input wire logic out_ready
);
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } stage_t;

  stage_t st;
  stage_t next_st;

  // One holding slot; it refills in the cycle it empties.
  assign in.ready = !st.valid || out_ready;

  always_comb begin
    next_st = st;
    if (in.ready) begin
      next_st.valid = in.valid;
      next_st.data = in.data;
      next_st.last = in.last;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '{valid: 1'b0, data: hub_desc_pkg::RESET_BYTE, last: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign out_valid = st.valid;
  assign out_data = st.data;
  assign out_last = st.last;
endmodule
`default_nettype wire

// ===== logic/hub_descriptor_responder.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Multi-TT interface and endpoint only in other-speed, when enabled.
// - Multi-TT interface: alt 01h, class 09h, protocol 02h.
// - Endpoint: 81h, interrupt, packet 0001h, interval 0Ch.
// - Device: 0200h, class 09h, protocol 01h, 40h.
// - Release defaults to revision byte, then 00h.
// - Vendor/product ids from loaded values else defaults.
// - Qualifier: ten bytes, type 06h, one configuration.
// - Configuration: total 0019h, one interface, value 01h.
// - Attributes A0h bus powered, E0h self powered.
// - Attributes always advertise remote wakeup.
// - Maximum power counts whole hub, 2mA units.
// - Maximum power chosen by power source bit.
// - Single-TT interface: alt zero, protocol 00h.
// - Other-speed: type 07h, total 0019h when single-TT, same power.
// - Lengths 12h, 09h, 09h, 07h per descriptor.
// - All string indices report 00h.
// - Multi-TT other-speed total length becomes 0029h.
module hub_descriptor_responder #(
  parameter int MAX_LEN_WIDTH = 16,
  // Arbitrary neutral identity defaults.
  parameter logic [15:0] VENDOR_DEFAULT = 16'h1234,
  parameter logic [15:0] PRODUCT_DEFAULT = 16'h5678
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Descriptor request
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [MAX_LEN_WIDTH-1:0] req_max_len,
  output logic req_ready,
  // Descriptor byte stream
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  input wire logic out_ready,
  // Transfer status
  output logic xfer_done,
  output logic busy,
  // Operating configuration
  input wire logic power_source_select,
  input wire logic multi_translator_enable,
  // Values from the configuration memory loader
  input wire logic ids_loaded,
  input wire logic [15:0] vendor_id_loaded,
  input wire logic [15:0] product_id_loaded,
  input wire logic [15:0] release_loaded,
  input wire logic [7:0] silicon_revision,
  input wire logic [7:0] max_current_bus_powered,
  input wire logic [7:0] max_current_self_powered
);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (MAX_LEN_WIDTH < 7) begin : g_bad_width
    $error("MAX_LEN_WIDTH must be at least 7");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    hub_desc_pkg::fsm_t fsm;
    hub_desc_pkg::desc_kind_t kind;
    logic power_self;
    logic multi_tt;
    logic [6:0] offset;
    logic [6:0] count;
    logic done;
  } responder_state_t;

  responder_state_t st;
  responder_state_t next_st;

  desc_byte_if offer ();

  logic [15:0] vendor_word;
  logic [15:0] product_word;
  logic [15:0] release_word;
  logic [15:0] release_default;
  logic [7:0] attr_byte;
  logic [7:0] power_byte;
  logic [6:0] desc_len;
  logic [6:0] send_len;
  logic [7:0] cur_byte;

  // ---------------------------------------------------------------
  // Loaded or built-in identity words
  // ---------------------------------------------------------------
  assign release_default = {silicon_revision, hub_desc_pkg::RELEASE_LOW};

  word_source u_vendor (
    .use_loaded(ids_loaded),
    .loaded_word(vendor_id_loaded),
    .default_word(VENDOR_DEFAULT),
    .word(vendor_word)
  );

  word_source u_product (
    .use_loaded(ids_loaded),
    .loaded_word(product_id_loaded),
    .default_word(PRODUCT_DEFAULT),
    .word(product_word)
  );

  word_source u_release (
    .use_loaded(ids_loaded),
    .loaded_word(release_loaded),
    .default_word(release_default),
    .word(release_word)
  );

  // ---------------------------------------------------------------
  // Power dependent fields
  // ---------------------------------------------------------------
  // Both encodings carry the remote wakeup bit, so no mode clears it.
  assign attr_byte = st.power_self ? hub_desc_pkg::ATTR_SELF
                                   : hub_desc_pkg::ATTR_BUS;
  // The loader already holds the whole-hub draw in 2mA units.
  assign power_byte = st.power_self ? max_current_self_powered
                                    : max_current_bus_powered;

  // ---------------------------------------------------------------
  // Descriptor byte tables
  // ---------------------------------------------------------------
  function automatic logic [7:0] device_byte(
    input logic [6:0] ofs,
    input logic [15:0] vid,
    input logic [15:0] pid,
    input logic [15:0] rel
  );
    case (ofs)
      7'h00: device_byte = hub_desc_pkg::LEN_DEVICE;
      7'h01: device_byte = hub_desc_pkg::TYPE_DEVICE;
      7'h02: device_byte = hub_desc_pkg::USB_RELEASE[7:0];
      7'h03: device_byte = hub_desc_pkg::USB_RELEASE[15:8];
      7'h04: device_byte = hub_desc_pkg::HUB_CLASS;
      7'h05: device_byte = hub_desc_pkg::HUB_SUBCLASS;
      7'h06: device_byte = hub_desc_pkg::DEV_PROTOCOL;
      7'h07: device_byte = hub_desc_pkg::EP0_MAX_PACKET;
      hub_desc_pkg::OFS_VENDOR: device_byte = vid[7:0];
      7'h09: device_byte = vid[15:8];
      hub_desc_pkg::OFS_PRODUCT: device_byte = pid[7:0];
      7'h0b: device_byte = pid[15:8];
      hub_desc_pkg::OFS_RELEASE: device_byte = rel[7:0];
      7'h0d: device_byte = rel[15:8];
      7'h0e: device_byte = hub_desc_pkg::STRING_NONE;
      7'h0f: device_byte = hub_desc_pkg::STRING_NONE;
      7'h10: device_byte = hub_desc_pkg::STRING_NONE;
      7'h11: device_byte = hub_desc_pkg::NUM_CONFIGS;
      default: device_byte = hub_desc_pkg::RESERVED_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] qualifier_byte(input logic [6:0] ofs);
    case (ofs)
      7'h00: qualifier_byte = hub_desc_pkg::LEN_QUALIFIER;
      7'h01: qualifier_byte = hub_desc_pkg::TYPE_QUALIFIER;
      7'h02: qualifier_byte = hub_desc_pkg::USB_RELEASE[7:0];
      7'h03: qualifier_byte = hub_desc_pkg::USB_RELEASE[15:8];
      7'h04: qualifier_byte = hub_desc_pkg::HUB_CLASS;
      7'h05: qualifier_byte = hub_desc_pkg::HUB_SUBCLASS;
      7'h06: qualifier_byte = hub_desc_pkg::QUAL_PROTOCOL;
      7'h07: qualifier_byte = hub_desc_pkg::EP0_MAX_PACKET;
      7'h08: qualifier_byte = hub_desc_pkg::NUM_CONFIGS;
      default: qualifier_byte = hub_desc_pkg::RESERVED_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] config_byte(
    input logic [6:0] ofs,
    input logic [7:0] dtype,
    input logic [15:0] total,
    input logic [7:0] attr,
    input logic [7:0] maxp
  );
    case (ofs)
      7'h00: config_byte = hub_desc_pkg::LEN_CONFIG;
      7'h01: config_byte = dtype;
      7'h02: config_byte = total[7:0];
      7'h03: config_byte = total[15:8];
      7'h04: config_byte = hub_desc_pkg::NUM_INTERFACES;
      7'h05: config_byte = hub_desc_pkg::CONFIG_VALUE;
      7'h06: config_byte = hub_desc_pkg::STRING_NONE;
      7'h07: config_byte = attr;
      7'h08: config_byte = maxp;
      default: config_byte = hub_desc_pkg::RESERVED_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] iface_byte(
    input logic [6:0] ofs,
    input logic [7:0] alt,
    input logic [7:0] proto
  );
    case (ofs)
      7'h00: iface_byte = hub_desc_pkg::LEN_INTERFACE;
      7'h01: iface_byte = hub_desc_pkg::TYPE_INTERFACE;
      7'h02: iface_byte = hub_desc_pkg::IF_NUMBER;
      7'h03: iface_byte = alt;
      7'h04: iface_byte = hub_desc_pkg::IF_ENDPOINTS;
      7'h05: iface_byte = hub_desc_pkg::HUB_CLASS;
      7'h06: iface_byte = hub_desc_pkg::HUB_SUBCLASS;
      7'h07: iface_byte = proto;
      7'h08: iface_byte = hub_desc_pkg::STRING_NONE;
      default: iface_byte = hub_desc_pkg::RESERVED_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] endpoint_byte(input logic [6:0] ofs);
    case (ofs)
      7'h00: endpoint_byte = hub_desc_pkg::LEN_ENDPOINT;
      7'h01: endpoint_byte = hub_desc_pkg::TYPE_ENDPOINT;
      7'h02: endpoint_byte = hub_desc_pkg::EP_ADDRESS;
      7'h03: endpoint_byte = hub_desc_pkg::EP_XFER_INTERRUPT;
      7'h04: endpoint_byte = hub_desc_pkg::EP_MAX_PACKET[7:0];
      7'h05: endpoint_byte = hub_desc_pkg::EP_MAX_PACKET[15:8];
      7'h06: endpoint_byte = hub_desc_pkg::EP_INTERVAL;
      default: endpoint_byte = hub_desc_pkg::RESERVED_ZERO;
    endcase
  endfunction

  // A configuration set is the configuration header followed by its
  // interface and endpoint; the multi-TT pair sits behind them and is
  // only reached when the length allows it.
  function automatic logic [7:0] set_byte(
    input logic [6:0] ofs,
    input logic [7:0] dtype,
    input logic [15:0] total,
    input logic [7:0] attr,
    input logic [7:0] maxp
  );
    if (ofs < hub_desc_pkg::SEG_IF0) begin
      set_byte = config_byte(ofs, dtype, total, attr, maxp);
    end else if (ofs < hub_desc_pkg::SEG_EP0) begin
      set_byte = iface_byte(ofs - hub_desc_pkg::SEG_IF0,
                            hub_desc_pkg::ALT_SINGLE,
                            hub_desc_pkg::PROTO_SINGLE);
    end else if (ofs < hub_desc_pkg::SEG_IF1) begin
      set_byte = endpoint_byte(ofs - hub_desc_pkg::SEG_EP0);
    end else if (ofs < hub_desc_pkg::SEG_EP1) begin
      set_byte = iface_byte(ofs - hub_desc_pkg::SEG_IF1,
                            hub_desc_pkg::ALT_MULTI,
                            hub_desc_pkg::PROTO_MULTI);
    end else begin
      set_byte = endpoint_byte(ofs - hub_desc_pkg::SEG_EP1);
    end
  endfunction

  // ---------------------------------------------------------------
  // Length and byte selection
  // ---------------------------------------------------------------
  always_comb begin
    case (st.kind)
      hub_desc_pkg::KIND_DEVICE: desc_len = hub_desc_pkg::LEN_DEVICE[6:0];
      hub_desc_pkg::KIND_QUALIFIER:
        desc_len = hub_desc_pkg::LEN_QUALIFIER[6:0];
      hub_desc_pkg::KIND_CONFIG:
        desc_len = hub_desc_pkg::TOTAL_SINGLE[6:0];
      hub_desc_pkg::KIND_OTHER_SPEED:
        desc_len = st.multi_tt ? hub_desc_pkg::TOTAL_MULTI[6:0]
                               : hub_desc_pkg::TOTAL_SINGLE[6:0];
      default: desc_len = hub_desc_pkg::TOTAL_SINGLE[6:0];
    endcase
  end

  always_comb begin
    case (st.kind)
      hub_desc_pkg::KIND_DEVICE:
        cur_byte = device_byte(st.offset, vendor_word, product_word,
                               release_word);
      hub_desc_pkg::KIND_QUALIFIER: cur_byte = qualifier_byte(st.offset);
      hub_desc_pkg::KIND_CONFIG:
        cur_byte = set_byte(st.offset, hub_desc_pkg::TYPE_CONFIG,
                            hub_desc_pkg::TOTAL_SINGLE, attr_byte,
                            power_byte);
      hub_desc_pkg::KIND_OTHER_SPEED:
        cur_byte = set_byte(st.offset, hub_desc_pkg::TYPE_OTHER_SPEED,
                            st.multi_tt ? hub_desc_pkg::TOTAL_MULTI
                                        : hub_desc_pkg::TOTAL_SINGLE,
                            attr_byte, power_byte);
      default: cur_byte = hub_desc_pkg::RESERVED_ZERO;
    endcase
  end

  // The host may ask for fewer bytes than the descriptor holds.
  assign send_len = (st.count < desc_len) ? st.count : desc_len;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  assign req_ready = (st.fsm == hub_desc_pkg::ST_IDLE);
  assign offer.valid = (st.fsm == hub_desc_pkg::ST_SEND);
  assign offer.data = cur_byte;
  assign offer.last = (st.offset == send_len - 7'h01);

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    case (st.fsm)
      hub_desc_pkg::ST_IDLE: begin
        if (req_valid) begin
          next_st.kind = hub_desc_pkg::desc_kind_t'(req_kind);
          // Mode bits are frozen for the whole transfer so that the
          // length field and the bytes sent always agree.
          next_st.power_self = power_source_select;
          next_st.multi_tt = multi_translator_enable;
          next_st.offset = hub_desc_pkg::RESET_COUNT;
          next_st.count = (req_max_len > MAX_LEN_WIDTH'(7'h7f)) ?
                          7'h7f : req_max_len[6:0];
          next_st.done = (req_max_len == '0);
          if (req_max_len != '0) begin
            next_st.fsm = hub_desc_pkg::ST_SEND;
          end
        end
      end
      hub_desc_pkg::ST_SEND: begin
        if (offer.ready) begin
          if (offer.last) begin
            next_st.fsm = hub_desc_pkg::ST_IDLE;
            next_st.done = 1'b1;
          end else begin
            next_st.offset = st.offset + 7'h01;
          end
        end
      end
      default: next_st.fsm = hub_desc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '{fsm: hub_desc_pkg::ST_IDLE,
              kind: hub_desc_pkg::KIND_DEVICE,
              power_self: 1'b0,
              multi_tt: 1'b0,
              offset: hub_desc_pkg::RESET_COUNT,
              count: hub_desc_pkg::RESET_COUNT,
              done: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign xfer_done = st.done;
  assign busy = (st.fsm == hub_desc_pkg::ST_SEND);

  // ---------------------------------------------------------------
  // Output stage
  // ---------------------------------------------------------------
  byte_stage u_stage (
    .core_clk(core_clk),
    .rstn(rstn),
    .in(offer),
    .out_valid(out_valid),
    .out_data(out_data),
    .out_last(out_last),
    .out_ready(out_ready)
  );

endmodule
`default_nettype wire

// ===== logic/word_source.sv
`timescale 1ns/1ns
`default_nettype none
module word_source (
  // Selection
  input wire logic use_loaded,
  // Candidate words
  input wire logic [15:0] loaded_word,
  input wire logic [15:0] default_word,
  // Result
  output logic [15:0] word
);
  assign word = use_loaded ? loaded_word : default_word;
endmodule
`default_nettype wire

// ===== verification/host_sink_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_sink_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Stall control from the bench
  input wire logic stall_en,
  // Byte stream from the hub
  input wire logic out_valid,
  output logic out_ready
);
  integer seed = 32'h91174bad;
  // A real host may refuse any byte, so stalls land at random places.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= stall_en ? 1'(($random(seed) & 3) != 0) : 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/hub_descriptor_responder_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module hub_descriptor_responder_assertions #(
  parameter int MAX_LEN_WIDTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Request side
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [MAX_LEN_WIDTH-1:0] req_max_len,
  input wire logic req_ready,
  // Byte stream and status
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  input wire logic out_ready,
  input wire logic xfer_done,
  input wire logic busy
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_take_bytes;
    req_valid && req_ready && req_max_len != '0;
  endsequence
  property p_take_busy;
    s_take_bytes |=> busy && !req_ready;
  endproperty
  a_take_busy: assert property (p_take_busy)
    else $error("request taken without going busy");
  property p_dev_len;
    s_take_bytes ##0 req_kind == 2'b00 |-> ##2 out_valid && out_data == 8'h12;
  endproperty
  a_dev_len: assert property (p_dev_len)
    else $error("device descriptor does not open with its length");
  property p_qual_len;
    s_take_bytes ##0 req_kind == 2'b01 |-> ##2 out_valid && out_data == 8'h0a;
  endproperty
  a_qual_len: assert property (p_qual_len)
    else $error("qualifier does not open with its length");
  property p_set_len;
    s_take_bytes ##0 req_kind[1] |-> ##2 out_valid && out_data == 8'h09;
  endproperty
  a_set_len: assert property (p_set_len)
    else $error("configuration set does not open with its length");
  property p_zero_len;
    s_take ##0 req_max_len == '0 |-> ##[1:2] (xfer_done && !out_valid);
  endproperty
  a_zero_len: assert property (p_zero_len)
    else $error("empty transfer did not finish at once");
  property p_hold;
    out_valid && !out_ready |=>
      out_valid && $stable(out_data) && $stable(out_last);
  endproperty
  a_hold: assert property (p_hold)
    else $error("byte changed while the host stalled");
  property p_last_end;
    out_valid && out_ready && out_last |=> !out_valid;
  endproperty
  a_last_end: assert property (p_last_end)
    else $error("bytes continue after the final byte");
  property p_done;
    xfer_done |=> !xfer_done && req_ready;
  endproperty
  a_done: assert property (p_done)
    else $error("done pulse too long or not idle after it");
endmodule
bind hub_descriptor_responder hub_descriptor_responder_assertions #(
  .MAX_LEN_WIDTH(MAX_LEN_WIDTH)
) chk_u (
  .core_clk(core_clk), .rstn(rstn), .req_valid(req_valid),
  .req_kind(req_kind), .req_max_len(req_max_len), .req_ready(req_ready),
  .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
  .out_ready(out_ready), .xfer_done(xfer_done), .busy(busy)
);
`default_nettype wire

// ===== verification/hub_descriptor_responder_tb.sv
`timescale 1ns/1ns
`default_nettype none
module hub_descriptor_responder_tb;
  // Arbitrary identity values.
  localparam logic [15:0] VID_DEF = 16'h2b7e;
  localparam logic [15:0] PID_DEF = 16'h6c19;
  localparam logic [15:0] CORNER [8] = '{16'h0000, 16'h0001, 16'h0019,
    16'h0029, 16'hffff, 16'h000a, 16'h0008, 16'h0028};
  logic core_clk = 1'b0, rstn = 1'b0, req_valid = 1'b0;
  logic [1:0] req_kind = 2'h0;
  logic [15:0] req_max_len = 16'h0000;
  logic pss = 1'b0, mtt = 1'b0, ids = 1'b0, stall_en = 1'b0;
  logic [15:0] vid = 16'h0000, pid = 16'h0000, rel = 16'h0000;
  logic [7:0] rev = 8'h00, mbp = 8'h00, msp = 8'h00, out_data;
  logic req_ready, out_valid, out_last, out_ready, xfer_done, busy;
  logic [7:0] exp_q[$], got_q[$];
  integer seed = 32'h91174bad;
  int fail_count = 0, n_compared = 0, last_at = 0;
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      got_q.push_back(out_data);
      if (out_last === 1'b1) last_at = got_q.size();
    end
  end
  hub_descriptor_responder #(.MAX_LEN_WIDTH(16), .VENDOR_DEFAULT(VID_DEF),
    .PRODUCT_DEFAULT(PID_DEF)) dut_u (
    .core_clk(core_clk), .rstn(rstn), .req_valid(req_valid),
    .req_kind(req_kind), .req_max_len(req_max_len), .req_ready(req_ready),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .out_ready(out_ready), .xfer_done(xfer_done), .busy(busy),
    .power_source_select(pss), .multi_translator_enable(mtt),
    .ids_loaded(ids), .vendor_id_loaded(vid), .product_id_loaded(pid),
    .release_loaded(rel), .silicon_revision(rev),
    .max_current_bus_powered(mbp), .max_current_self_powered(msp));
  host_sink_model host_u (.core_clk(core_clk), .rstn(rstn),
    .stall_en(stall_en), .out_valid(out_valid), .out_ready(out_ready));
  task final_report();
    if (fail_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic build(input logic [1:0] k);
    logic [15:0] v, p, r, tot;
    v = ids ? vid : VID_DEF;
    p = ids ? pid : PID_DEF;
    r = ids ? rel : {rev, 8'h00};
    tot = (k == 2'b11 && mtt) ? 16'h0029 : 16'h0019;
    case (k)
      2'b00: exp_q = {8'h12, 8'h01, 8'h00, 8'h02, 8'h09, 8'h00, 8'h01, 8'h40,
        v[7:0], v[15:8], p[7:0], p[15:8], r[7:0], r[15:8], 8'h00, 8'h00,
        8'h00, 8'h01};
      2'b01: exp_q = {8'h0a, 8'h06, 8'h00, 8'h02, 8'h09, 8'h00, 8'h00, 8'h40,
        8'h01, 8'h00};
      default: begin
        exp_q = {8'h09, k[0] ? 8'h07 : 8'h02, tot[7:0], tot[15:8], 8'h01,
          8'h01, 8'h00, pss ? 8'he0 : 8'ha0, pss ? msp : mbp, 8'h09, 8'h04,
          8'h00, 8'h00, 8'h01, 8'h09, 8'h00, 8'h00, 8'h00, 8'h07, 8'h05,
          8'h81, 8'h03, 8'h01, 8'h00, 8'h0c};
        if (tot == 16'h0029) exp_q = {exp_q, 8'h09, 8'h04, 8'h00, 8'h01,
          8'h01, 8'h09, 8'h00, 8'h02, 8'h00, 8'h07, 8'h05, 8'h81, 8'h03,
          8'h01, 8'h00, 8'h0c};
      end
    endcase
  endtask
  task rnd(input logic force_mtt);
    @(posedge core_clk);
    {pss, ids, stall_en, mtt} <= 4'($random(seed)) | {3'b000, force_mtt};
    {vid, pid} <= $random(seed);
    {rel, rev} <= 24'($random(seed));
    {mbp, msp} <= 16'($random(seed));
  endtask
  task automatic run(input logic [1:0] k, input logic [15:0] ml,
    input logic spur);
    int n;
    int i;
    @(posedge core_clk);
    build(k);
    n = (int'(ml) < exp_q.size()) ? int'(ml) : exp_q.size();
    got_q = {};
    last_at = 0;
    req_valid <= 1'b1;
    req_kind <= k;
    req_max_len <= ml;
    @(posedge core_clk);
    // Holding the strobe while busy must not start a second transfer.
    if (spur && ml > 16'h0001) @(posedge core_clk);
    req_valid <= 1'b0;
    i = 0;
    while (xfer_done !== 1'b1 && i < 300) begin
      @(negedge core_clk);
      i++;
    end
    while ((busy !== 1'b0 || out_valid !== 1'b0) && i < 300) begin
      @(negedge core_clk);
      i++;
    end
    if (i >= 300) begin
      fail_count++;
      final_report();
    end
    chk(8'(got_q.size()), 8'(n));
    chk(8'(last_at), 8'(n));
    for (i = 0; i < n && i < got_q.size(); i++)
      chk(got_q[i], exp_q[i]);
    if (k[1] && n > 8) begin
      chk(got_q[7], pss ? 8'he0 : 8'ha0);
      chk(got_q[8], pss ? msp : mbp);
    end
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    for (int t = 0; t < 80; t++) begin
      rnd(t < 8 && t[0]);
      run(t[1:0], t < 8 ? CORNER[t] : 16'($random(seed) & 63), t[2]);
    end
    final_report();
  end
endmodule
`default_nettype wire
